// File: hdl/isrs_pkg.sv
// isrs_pkg: shared constants and types of the integrator reset steering pair
// assumes a single 40 MHz clock on both ends
package isrs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  // watchdog_limit_time, lowest detect time, rounded down
  localparam int WD_LIMIT_NS = 30000;
  localparam int WD_CYCLES = WD_LIMIT_NS / CLK_PERIOD_NS;
  // least integrator reset hold time, rounded up
  localparam int HOLD_NS = 150;
  localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // programmed timed reset pulse, rounded up
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-up calibration during which inputs are ignored
  localparam int CAL_NS = 20000;
  localparam int CAL_CYCLES = (CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // ==========================================================
  // data
  localparam int SAMPLE_W = 8;
  localparam logic [SAMPLE_W-1:0] MIN_LEVEL = 8'h00;
  typedef enum logic [2:0] {
    ISRS_SINGLE = 3'b001,
    ISRS_PP2 = 3'b010,
    ISRS_PP4 = 3'b100
  } isrs_mode_e;
  // ==========================================================
  // controller register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RST_LEN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MEAS_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LIVE = 8'h14;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [1:0] MODE_CODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CODE_PP2 = 2'h1;
  localparam logic [1:0] MODE_CODE_PP4 = 2'h2;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_RECOVER_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LEN_RESET = 16'h0010;
  localparam logic [DATA_W-1:0] MEAS_LEN_RESET = 16'h0100;
  localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;
endpackage : isrs_pkg

// File: hdl/isrs_link.sv
// isrs_link: gate timing pins from controller to sensor, fault back
// assumes both ends share mclk; the sensor still synchronises its inputs
`timescale 1ns/100ps
interface isrs_link;
  logic gate_timing_in_a;
  logic gate_timing_in_b;
  logic gate_timing_in_c;
  logic gate_timing_in_d;
  logic mode_sel;
  logic fault_n;
  modport sensor (
    input gate_timing_in_a, gate_timing_in_b, gate_timing_in_c,
    input gate_timing_in_d, mode_sel,
    output fault_n
  );
  modport ctrl (
    output gate_timing_in_a, gate_timing_in_b, gate_timing_in_c,
    output gate_timing_in_d, mode_sel,
    input fault_n
  );
endinterface : isrs_link

// File: hdl/isrs_sync.sv
// isrs_sync: two-flop synchroniser for a group of level inputs
// assumes levels change slowly compared with mclk
`timescale 1ns/100ps
module isrs_sync #(
  parameter int WIDTH = 1
) (
  // clocking
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : isrs_sync

// File: hdl/isrs_sensor.sv
// isrs_sensor: sensor end; reset logic, timer, steering, watchdog
// assumes gate timing arrives from another party on isrs_link
// Overview of operation
// [R1] fault_n low when measurement outlasts watchdog
// [R2] dual variant three modes, single variant one
// [R3] single mode always uses first channel
// [R4] ping-pong alternates channels per measurement
// [R5] controller keeps input c low in 2-wire
// [R6] 2-wire: a high first, b high second
// [R7] 4-wire: a&~b second, c&~d first channel
// [R8] full bridge should prefer 4-wire mode
// [R9] mode from mode_sel and input d levels
// [R10] single variant reset is a xor b
// [R11] three reset functions, one per mode
// [R12] reset completes before each measurement
// [R13] controller timing meets hold and watchdog; code caps measurement only, reset length unchecked against hold
// [R14] timer tied: reset follows logic exactly
// [R15] timer on: retriggerable pulse on rise
// [R16] logic falling ends timed reset at once
// [R17] timeout holds outputs minimum, next reset clears
// [R18] inputs synchronised, times are cycle counts
// [R19] unselected channel held at minimum
`timescale 1ns/100ps
module isrs_sensor #(
  parameter bit DUAL_OUT = 1'b1
) (
  // clocking
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // gate timing pins and fault alert
  isrs_link.sensor link,
  // board strap and measured current
  input wire logic timer_tied,
  input wire logic [isrs_pkg::SAMPLE_W-1:0] meas_sample,
  // outputs
  output logic [isrs_pkg::SAMPLE_W-1:0] sense_wave_a,
  output logic [isrs_pkg::SAMPLE_W-1:0] sense_wave_b,
  output logic integ_reset
);
  import isrs_pkg::*;

  typedef enum logic [4:0] {
    ST_CAL = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_RST = 5'b00100,
    ST_MEAS = 5'b01000,
    ST_FAULT = 5'b10000
  } isrs_state_e;

  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_MIN = CNT_W'(HOLD_CYCLES);

  // ==========================================================
  // input synchronisation
  logic [4:0] pins_sync;
  logic in_a, in_b, in_c, in_d, in_mode;

  isrs_sync #(.WIDTH(5)) u_sync ( // R18
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async_in({link.mode_sel, link.gate_timing_in_d,
      link.gate_timing_in_c, link.gate_timing_in_b,
      link.gate_timing_in_a}),
    .sync_out(pins_sync)
  );
  assign {in_mode, in_d, in_c, in_b, in_a} = pins_sync;

  // ==========================================================
  // mode decode and reset logic functions
  isrs_mode_e mode;
  logic rlog;

  // mode follows static pin levels; single variant ignores them
  always_comb begin
    if (!DUAL_OUT) begin
      mode = ISRS_SINGLE; // R2
    end else if (!in_mode) begin
      mode = ISRS_PP4; // R9
    end else if (in_d) begin
      mode = ISRS_PP2; // R9
    end else begin
      mode = ISRS_SINGLE; // R9
    end
  end

  // one expression per mode, only the selected mode's expression can start a reset
  always_comb begin
    rlog = 1'b0;
    if (!DUAL_OUT) begin
      rlog = in_a ^ in_b; // R10
    end else begin
      unique case (mode)
        ISRS_SINGLE: rlog = in_a ^ (in_b | in_c); // R11
        ISRS_PP2: rlog = ~(in_a ^ (in_b | in_c)); // R11
        ISRS_PP4: rlog = (in_a & in_b) | (in_c & in_d); // R11
        default: rlog = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // state register and counters
  isrs_state_e state_q, state_d;
  logic [CNT_W-1:0] cal_cnt_q;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] pulse_cnt_q;
  logic [CNT_W-1:0] rst_len_q;
  logic rlog_q;
  logic rlog_rise;
  logic live_rlog;
  logic hold_ok_q;
  logic chan_b_q;
  logic chan_b_d;
  logic fault_q;

  // inputs are ignored until calibration is over
  assign live_rlog = rlog & (state_q != ST_CAL);
  assign rlog_rise = live_rlog & ~rlog_q;

  // ==========================================================
  // integrator reset: follower or retriggerable timer
  always_ff @(posedge mclk) begin
    if (rst) begin
      rlog_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (ce) begin
      rlog_q <= live_rlog;
      if (!live_rlog) begin
        pulse_cnt_q <= '0; // R16
      end else if (rlog_rise) begin
        pulse_cnt_q <= PULSE_LOAD; // R15
      end else if (pulse_cnt_q != '0) begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  // a timed pulse never outlives the logic that started it
  always_comb begin
    if (timer_tied) begin
      integ_reset = live_rlog; // R14
    end else begin
      integ_reset = live_rlog & (rlog_rise | (pulse_cnt_q != '0)); // R16
    end
  end

  // ==========================================================
  // sequence: calibrate, wait, reset, measure, fault
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_CAL: if (cal_cnt_q == CAL_LAST) state_d = ST_WAIT;
      ST_WAIT: if (integ_reset) state_d = ST_RST;
      ST_RST: if (!integ_reset) state_d = ST_MEAS; // R12
      ST_MEAS: begin
        if (integ_reset) begin
          state_d = ST_RST;
        end else if (wd_cnt_q == WD_LAST) begin
          state_d = ST_FAULT; // R1
        end
      end
      ST_FAULT: if (integ_reset) state_d = ST_RST; // R17
      default: state_d = ST_CAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_CAL;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // calibration and watchdog counters
  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_cnt_q <= '0;
      wd_cnt_q <= '0;
    end else if (ce) begin
      if (state_q == ST_CAL) begin
        cal_cnt_q <= cal_cnt_q + 1'b1;
      end
      if (state_q == ST_MEAS && !integ_reset) begin
        wd_cnt_q <= wd_cnt_q + 1'b1; // R18
      end else begin
        wd_cnt_q <= '0;
      end
    end
  end

  // a reset shorter than the hold time leaves the integrator dirty
  always_ff @(posedge mclk) begin
    if (rst) begin
      rst_len_q <= '0;
      hold_ok_q <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_RST) begin
        if (rst_len_q != HOLD_MIN) begin
          rst_len_q <= rst_len_q + 1'b1;
        end
        hold_ok_q <= (rst_len_q == HOLD_MIN); // R12
      end else begin
        rst_len_q <= '0;
      end
    end
  end

  // ==========================================================
  // channel steering; the output stage reads the next value so the
  // first sample of a measurement already lands on the right channel
  always_comb begin
    chan_b_d = chan_b_q;
    unique case (mode)
      ISRS_SINGLE: chan_b_d = 1'b0; // R3
      ISRS_PP2: begin
        if (in_a) begin
          chan_b_d = 1'b0; // R6
        end else if (in_b) begin
          chan_b_d = 1'b1; // R6
        end
      end
      ISRS_PP4: begin
        if (in_a && !in_b) begin
          chan_b_d = 1'b1; // R7
        end else if (in_c && !in_d) begin
          chan_b_d = 1'b0; // R7
        end
      end
      default: chan_b_d = 1'b0;
    endcase
  end

  // latched so a channel holds through the reset that follows
  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_b_q <= 1'b0;
    end else if (ce && state_q != ST_CAL) begin
      chan_b_q <= chan_b_d;
    end
  end

  // ==========================================================
  // outputs: measured sample on the chosen channel, else minimum
  always_ff @(posedge mclk) begin
    if (rst) begin
      sense_wave_a <= MIN_LEVEL;
      sense_wave_b <= MIN_LEVEL;
      fault_q <= 1'b0;
    end else if (ce) begin
      fault_q <= (state_d == ST_FAULT); // R1
      sense_wave_a <= MIN_LEVEL; // R19
      sense_wave_b <= MIN_LEVEL; // R19
      if (state_d == ST_MEAS && hold_ok_q) begin
        if (chan_b_d) begin
          sense_wave_b <= meas_sample; // R4
        end else begin
          sense_wave_a <= meas_sample; // R4
        end
      end
    end
  end

  assign link.fault_n = ~fault_q; // R17
endmodule : isrs_sensor

// File: hdl/isrs_ctrl.sv
// isrs_ctrl: controller end; generates gate timing, watches fault
// assumes software on a plain register port, read data one cycle later
`timescale 1ns/100ps
module isrs_ctrl (
  // clocking
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [isrs_pkg::ADDR_W-1:0] addr,
  input wire logic [isrs_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [isrs_pkg::DATA_W-1:0] rdata,
  output logic irq,
  // gate timing pins
  isrs_link.ctrl link
);
  import isrs_pkg::*;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_RST1 = 5'b00010,
    PH_MEAS1 = 5'b00100,
    PH_RST2 = 5'b01000,
    PH_MEAS2 = 5'b10000
  } isrs_phase_e;

  localparam logic [CNT_W-1:0] MEAS_MAX = CNT_W'(WD_CYCLES / 2);

  logic [DATA_W-1:0] ctrl_q, rst_len_q, meas_len_q;
  logic [STAT_W-1:0] status_q, mask_q;
  logic [1:0] mode_code;
  logic [CNT_W-1:0] cnt_q, meas_eff;
  isrs_phase_e ph_q;
  logic fault_s, fault_prev_q;

  assign mode_code = ctrl_q[CTRL_MODE_LSB +: 2];
  // gaps kept well under the watchdog limit
  assign meas_eff = (meas_len_q > MEAS_MAX) ? MEAS_MAX : meas_len_q; // R13

  isrs_sync #(.WIDTH(1)) u_fault_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async_in(~link.fault_n),
    .sync_out(fault_s)
  );

  // ==========================================================
  // register writes and sticky status, set wins over read clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      rst_len_q <= RST_LEN_RESET;
      meas_len_q <= MEAS_LEN_RESET;
      mask_q <= MASK_RESET;
      status_q <= '0;
      fault_prev_q <= 1'b0;
      rdata <= '0;
    end else if (ce) begin
      fault_prev_q <= fault_s;
      if (wr) begin
        unique case (addr)
          REG_CTRL: ctrl_q <= wdata;
          REG_RST_LEN: rst_len_q <= wdata;
          REG_MEAS_LEN: meas_len_q <= wdata;
          REG_MASK: mask_q <= wdata[STAT_W-1:0];
          default: ;
        endcase
      end
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          REG_CTRL: rdata <= ctrl_q;
          REG_RST_LEN: rdata <= rst_len_q;
          REG_MEAS_LEN: rdata <= meas_len_q;
          REG_STATUS: rdata <= DATA_W'(status_q);
          REG_MASK: rdata <= DATA_W'(mask_q);
          REG_LIVE: rdata <= {10'h000, ph_q, fault_s};
          default: rdata <= '0;
        endcase
      end
      status_q <= (rd && addr == REG_STATUS) ? '0 : status_q;
      if (fault_s && !fault_prev_q) status_q[STAT_FAULT_BIT] <= 1'b1;
      if (!fault_s && fault_prev_q) status_q[STAT_RECOVER_BIT] <= 1'b1;
    end
  end

  assign irq = |(status_q & mask_q);

  // ==========================================================
  // phase sequencer: reset, measure, reset, measure
  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q <= PH_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      if (!ctrl_q[CTRL_RUN_BIT]) begin
        ph_q <= PH_IDLE;
        cnt_q <= '0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else begin
        unique case (ph_q)
          PH_IDLE, PH_MEAS2: begin
            ph_q <= PH_RST1;
            cnt_q <= rst_len_q; // R12
          end
          PH_RST1: begin
            ph_q <= PH_MEAS1;
            cnt_q <= meas_eff;
          end
          PH_MEAS1: begin
            ph_q <= PH_RST2;
            cnt_q <= rst_len_q; // R12
          end
          PH_RST2: begin
            ph_q <= PH_MEAS2;
            cnt_q <= meas_eff;
          end
          default: ph_q <= PH_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // pin patterns per mode; c is held low outside 4-wire
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.gate_timing_in_a <= 1'b0;
      link.gate_timing_in_b <= 1'b0;
      link.gate_timing_in_c <= 1'b0;
      link.gate_timing_in_d <= 1'b0;
      link.mode_sel <= 1'b1;
    end else if (ce) begin
      link.gate_timing_in_c <= 1'b0; // R5
      unique case (mode_code)
        MODE_CODE_PP2: begin
          link.mode_sel <= 1'b1;
          link.gate_timing_in_d <= 1'b1;
          link.gate_timing_in_a <= (ph_q == PH_MEAS1);
          link.gate_timing_in_b <= (ph_q == PH_MEAS2);
        end
        MODE_CODE_PP4: begin
          link.mode_sel <= 1'b0; // R8
          link.gate_timing_in_a <= (ph_q == PH_RST1) || (ph_q == PH_MEAS1);
          link.gate_timing_in_b <= (ph_q == PH_RST1);
          link.gate_timing_in_c <= (ph_q == PH_RST2) || (ph_q == PH_MEAS2);
          link.gate_timing_in_d <= (ph_q == PH_RST2);
        end
        default: begin
          link.mode_sel <= 1'b1;
          link.gate_timing_in_d <= 1'b0;
          link.gate_timing_in_a <= (ph_q == PH_RST1) || (ph_q == PH_RST2);
          link.gate_timing_in_b <= 1'b0;
        end
      endcase
    end
  end
endmodule : isrs_ctrl

// File: bench/isrs_link_chk.sv
// isrs_link_chk: concurrent checks on the gate timing link and fault alert
// assumes one mclk domain; pins are registered by the controller end
`timescale 1ns/100ps
module isrs_link_chk (
  // clocking
  input wire logic mclk,
  input wire logic rst,
  // link signals
  input wire logic gate_timing_in_a,
  input wire logic gate_timing_in_b,
  input wire logic gate_timing_in_c,
  input wire logic gate_timing_in_d,
  input wire logic mode_sel,
  input wire logic fault_n
);
  import isrs_pkg::*;
  localparam int QUIET = CAL_CYCLES + WD_CYCLES;
  logic rf;
  logic seen_q;
  logic [CNT_W-1:0] meas_q;
  logic [CNT_W-1:0] since_q;
  default clocking cb @(posedge mclk); endclocking
  // ==========================================================
  // helper logic
  // live reset function; d folds the 2-wire inversion into one xor
  assign rf = !mode_sel ? (gate_timing_in_a & gate_timing_in_b) |
      (gate_timing_in_c & gate_timing_in_d) : gate_timing_in_d ^
      gate_timing_in_a ^ (gate_timing_in_b | gate_timing_in_c);
  // cycles since release, saturating so it never wraps
  always_ff @(posedge mclk) begin
    if (rst) begin
      since_q <= '0;
    end else if (since_q < CNT_W'(QUIET)) begin
      since_q <= since_q + 1'b1;
    end
  end
  // a reset seen after calibration arms the watchdog view
  always_ff @(posedge mclk) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (rf && since_q > CNT_W'(CAL_CYCLES + 4)) begin
      seen_q <= 1'b1;
    end
  end
  // raw measuring time; leads the sensor by its synchroniser
  always_ff @(posedge mclk) begin
    if (rst || rf) begin
      meas_q <= '0;
    end else if (seen_q && meas_q != '1) begin
      meas_q <= meas_q + 1'b1;
    end
  end
  // ==========================================================
  // assertions
  sequence s_long_meas;
    seen_q && meas_q == CNT_W'(WD_CYCLES + 8);
  endsequence
  sequence s_reset_start;
    !fault_n ##0 $rose(rf);
  endsequence
  chk_rst_fault_high: assert property (rst |=> fault_n)
    else $error("fault alert low after reset");
  chk_rst_pins_idle: assert property (rst |=> !gate_timing_in_a &&
      !gate_timing_in_b && !gate_timing_in_c && !gate_timing_in_d && mode_sel)
    else $error("gate pins not idle after reset");
  chk_pp2_c_low: assert property (disable iff (rst)
      mode_sel && gate_timing_in_d |-> !gate_timing_in_c)
    else $error("third gate input high in 2-wire mode");
  chk_fault_late_only: assert property (disable iff (rst)
      $fell(fault_n) |-> $past(meas_q, 3) >= CNT_W'(WD_CYCLES - 8))
    else $error("fault alert before watchdog limit");
  chk_fault_on_limit: assert property (disable iff (rst)
      s_long_meas |-> !fault_n)
    else $error("no fault alert after watchdog limit");
  chk_fault_clears: assert property (disable iff (rst)
      s_reset_start |-> ##[1:6] fault_n)
    else $error("fault alert not cleared by reset start");
  chk_fault_holds: assert property (disable iff (rst)
      !fault_n && !rf && meas_q > 16'h0004 |=> !fault_n)
    else $error("fault alert cleared without reset");
  chk_cal_no_fault: assert property (disable iff (rst)
      since_q < CNT_W'(QUIET) |-> fault_n)
    else $error("fault alert during calibration window");
endmodule : isrs_link_chk

// File: bench/isrs_tb.sv
// isrs_tb: controller and sensor joined on the link, driven by registers
// assumes one 40 MHz clock; reset held 20 cycles at start
`timescale 1ns/100ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module isrs_tb;
  import isrs_pkg::*;
  logic mclk, rst, timer_tied, wr, rd, irq, integ_reset;
  logic [SAMPLE_W-1:0] meas_sample, sense_wave_a, sense_wave_b;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [4:0] pins;
  logic ce, sv_reset;
  logic [SAMPLE_W-1:0] sv_wave_a, sv_wave_b;
  int miscompares = 0;
  int compares = 0;
  // ==========================================================
  // design pair and checker
  isrs_link isrs_link_inst ();
  isrs_ctrl isrs_ctrl_inst (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .link(isrs_link_inst));
  isrs_sensor #(.DUAL_OUT(1'b1)) isrs_sensor_inst (.mclk(mclk), .rst(rst),
    .ce(ce), .link(isrs_link_inst), .timer_tied(timer_tied),
    .meas_sample(meas_sample), .sense_wave_a(sense_wave_a),
    .sense_wave_b(sense_wave_b), .integ_reset(integ_reset));
  // single output variant listening on a copy of the pins
  isrs_link isrs_link_sv ();
  assign {isrs_link_sv.mode_sel, isrs_link_sv.gate_timing_in_d,
    isrs_link_sv.gate_timing_in_c, isrs_link_sv.gate_timing_in_b,
    isrs_link_sv.gate_timing_in_a} = pins;
  isrs_sensor #(.DUAL_OUT(1'b0)) isrs_sensor_sv_inst (.mclk(mclk), .rst(rst),
    .ce(ce), .link(isrs_link_sv), .timer_tied(timer_tied),
    .meas_sample(meas_sample), .sense_wave_a(sv_wave_a),
    .sense_wave_b(sv_wave_b), .integ_reset(sv_reset));
  isrs_link_chk isrs_link_chk_inst (.mclk(mclk), .rst(rst),
    .gate_timing_in_a(isrs_link_inst.gate_timing_in_a),
    .gate_timing_in_b(isrs_link_inst.gate_timing_in_b),
    .gate_timing_in_c(isrs_link_inst.gate_timing_in_c),
    .gate_timing_in_d(isrs_link_inst.gate_timing_in_d),
    .mode_sel(isrs_link_inst.mode_sel), .fault_n(isrs_link_inst.fault_n));
  // pin view {mode_sel, d, c, b, a}
  assign pins = {isrs_link_inst.mode_sel, isrs_link_inst.gate_timing_in_d,
    isrs_link_inst.gate_timing_in_c, isrs_link_inst.gate_timing_in_b,
    isrs_link_inst.gate_timing_in_a};
  // free running clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================================
  // helpers
  // expected reset function of a pin view, 2-wire as inverted single
  function automatic logic rf_f(logic [4:0] p);
    return p[4] ? p[3] ^ p[0] ^ (p[1] | p[2]) : (p[0] & p[1]) | (p[2] & p[3]);
  endfunction : rf_f
  task automatic test_done();
    $display("counts compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  // bounded wait on fault alert (f=1) or integrator reset (f=0)
  task automatic wait_sig(logic f, logic v);
    int k = 0;
    while ((f ? isrs_link_inst.fault_n : integ_reset) !== v) begin
      @(posedge mclk);
      #1;
      k++;
      if (k == 4000) begin
        miscompares++;
        test_done();
      end
    end
  endtask : wait_sig
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [ADDR_W-1:0] ra [7] = '{REG_CTRL, REG_RST_LEN, REG_MEAS_LEN,
      REG_MASK, REG_STATUS, REG_LIVE, 8'h2c};
    logic [DATA_W-1:0] re [7] = '{CTRL_RESET, RST_LEN_RESET, MEAS_LEN_RESET,
      16'(MASK_RESET), 16'h0000, 16'h0002, 16'h0000};
    @(posedge mclk);
    #1;
    `CHK(pins, 5'h10)
    `CHK({isrs_link_inst.fault_n, irq, integ_reset, sense_wave_a,
      sense_wave_b}, 19'h40000)
    for (int j = 0; j < 7; j++) begin
      rd_chk(ra[j], re[j]);
    end
    wr_reg(8'h2c, 16'hffff);
    rd_chk(8'h2c, 16'h0000);
    $display("done reset test");
  endtask : t_reset
  // run one mode, follow reset function and channel steering
  task automatic t_mode(logic [1:0] m);
    logic [4:0] h1 = '0, h2 = '0;
    logic pa = 1'b0, pb = 1'b0, an, bn;
    int last = 0, na = 0, nb = 0;
    wr_reg(REG_CTRL, {13'h0000, m, 1'b1});
    for (int i = 0; i < 1500; i++) begin
      @(posedge mclk);
      #1;
      an = |sense_wave_a;
      bn = |sense_wave_b;
      if (i > 8) begin
        `CHK(integ_reset, rf_f(h2))
        `CHK(an & bn, 1'b0)
        `CHK(isrs_link_inst.fault_n, 1'b1)
        `CHK(sv_reset, h2[0] ^ h2[1])
        `CHK(sv_wave_b, MIN_LEVEL)
        if (m == MODE_CODE_SINGLE) `CHK(bn, 1'b0)
        if (an && !pa) begin
          na++;
          if (m != MODE_CODE_SINGLE) `CHK({last == 1, m == MODE_CODE_PP2 ?
            h2[0] : h2[2] & ~h2[3]}, 2'b01)
          last = 1;
        end
        if (bn && !pb) begin
          nb++;
          `CHK({last == 2, m == MODE_CODE_PP2 ? h2[1] : h2[0] & ~h2[1]},
            2'b01)
          last = 2;
        end
      end
      pa = an;
      pb = bn;
      h2 = h1;
      h1 = pins;
    end
    `CHK(na > 0, 1'b1)
    if (m != MODE_CODE_SINGLE) `CHK(nb > 0, 1'b1)
    $display("done mode test %0d", m);
  endtask : t_mode
  // timed pulse: capped by the timer, cut short when logic falls
  task automatic t_timer();
    logic [DATA_W-1:0] lens [2] = '{16'h0009, 16'h003f};
    int n, e;
    @(posedge mclk);
    timer_tied <= 1'b0;
    wr_reg(REG_CTRL, 16'h0001);
    foreach (lens[j]) begin
      wr_reg(REG_RST_LEN, lens[j]);
      e = int'(lens[j]) + 1;
      e = (e > PULSE_CYCLES) ? PULSE_CYCLES : e;
      repeat (2) begin
        n = 0;
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b0, 1'b1);
        while (integ_reset === 1'b1 && n < 500) begin
          @(posedge mclk);
          #1;
          n++;
        end
      end
      `CHK(n, e)
    end
    @(posedge mclk);
    timer_tied <= 1'b1;
    wr_reg(REG_RST_LEN, RST_LEN_RESET);
    $display("done timer test");
  endtask : t_timer
  // stop resets: watchdog fault, masked then unmasked irq, recovery
  task automatic t_fault();
    wr_reg(REG_MASK, 16'h0002);
    wr_reg(REG_CTRL, 16'h0000);
    wait_sig(1'b1, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    `CHK({sense_wave_a, sense_wave_b, sv_wave_a, irq, isrs_link_sv.fault_n},
      26'h0000000)
    wr_reg(REG_MASK, 16'h0003);
    @(posedge mclk);
    #1;
    `CHK(irq, 1'b1)
    rd_chk(REG_STATUS, 16'h0001);
    @(posedge mclk);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(REG_CTRL, 16'h0001);
    wait_sig(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    rd_chk(REG_STATUS, 16'h0002);
    $display("done fault test");
  endtask : t_fault
  // clock enable low freezes both ends; long enough for a phase change
  task automatic t_freeze();
    logic [22:0] snap;
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    #1;
    snap = {pins, isrs_link_inst.fault_n, integ_reset, sense_wave_a,
      sense_wave_b};
    repeat (300) @(posedge mclk);
    #1;
    `CHK({pins, isrs_link_inst.fault_n, integ_reset, sense_wave_a,
      sense_wave_b}, snap)
    @(posedge mclk);
    ce <= 1'b1;
    $display("done freeze test");
  endtask : t_freeze
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    timer_tied = 1'b1;
    meas_sample = 8'h5a;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    repeat (CAL_CYCLES) @(posedge mclk);
    t_mode(MODE_CODE_SINGLE);
    t_mode(MODE_CODE_PP2);
    t_mode(MODE_CODE_PP4);
    t_freeze();
    t_timer();
    t_fault();
    test_done();
  end
endmodule : isrs_tb
